// ===== mcms_regs.svh
// offsets, field positions, reset values and timing counts of the management slave
// assumes the core clock runs at the rate given by MCMS_CLK_MHZ
`ifndef MCMS_REGS_SVH
`define MCMS_REGS_SVH

// core clock and the lamp sensing window after any reset event
`define MCMS_CLK_MHZ 200
`define MCMS_SENSE_NS 100
`define MCMS_SENSE_CYCLES ((`MCMS_SENSE_NS * `MCMS_CLK_MHZ + 999) / 1000)

// frame field codes
`define MCMS_ST_C22 2'h1
`define MCMS_OP_WRITE 2'h1
`define MCMS_OP_READ 2'h2

// index of the bit sampled last in each frame field, bit 0 is the first start bit
`define MCMS_BIT_ST_END 5'h01
`define MCMS_BIT_OP_END 5'h03
`define MCMS_BIT_PHY_END 5'h08
`define MCMS_BIT_REG_END 5'h0d
`define MCMS_BIT_TA1 5'h0e
`define MCMS_BIT_TA2 5'h0f
`define MCMS_BIT_LAST 5'h1f

// register addresses
`define MCMS_REG_CTRL 5'h00
`define MCMS_REG_STAT 5'h01
`define MCMS_REG_EVT 5'h02
`define MCMS_REG_LAMP 5'h03

// field positions
`define MCMS_CTRL_RST 15
`define MCMS_CTRL_LOOP 14
`define MCMS_CTRL_ANEN 12
`define MCMS_CTRL_PDN 11
`define MCMS_STAT_RFLT 4
`define MCMS_STAT_LINK 2
`define MCMS_STAT_JAB 1
`define MCMS_EVT_PAGE 0
`define MCMS_LAMP_A_LSB 0
`define MCMS_LAMP_B_LSB 2
`define MCMS_LAMP_A_SENSED 8
`define MCMS_LAMP_B_SENSED 9

// reset values of fields not taken from straps
`define MCMS_RST_LOOP 1'h0
`define MCMS_RST_LAMP_MODE 2'h0

`endif

// ===== mcms_pkg.sv
// types shared by the management slave files
// assumes the constants of mcms_regs.svh for field meanings
package mcms_pkg;

   // link side frame state
   typedef enum logic [1:0]
   {
      MCMS_IDLE = 2'b00,
      MCMS_ACTIVE = 2'b01,
      MCMS_IGNORE = 2'b10
   } mcms_link_state_t;

   // lamp drive polarity selection
   typedef enum logic [1:0]
   {
      MCMS_LAMP_AUTO = 2'b00,
      MCMS_LAMP_HIGH = 2'b01,
      MCMS_LAMP_LOW = 2'b10
   } mcms_lamp_mode_t;

   // all state clocked by the management clock
   typedef struct packed
   {
      logic rstS1;
      logic rstS2;
      logic [4:0] phyS1;
      logic [4:0] phyS2;
      mcms_link_state_t state;
      logic [4:0] bitCnt;
      logic lastBit;
      logic [15:0] sreg;
      logic isWrite;
      logic [4:0] regAddr;
      logic [15:0] txShift;
      logic [15:0] readWord;
      logic mdioOut;
      logic mdioOe;
      logic postToggle;
      logic postWr;
      logic [4:0] postAddr;
      logic [15:0] postData;
   } mcms_link_st_t;

   // all state clocked by the core clock
   typedef struct packed
   {
      logic [6:0] strapS1;
      logic [6:0] strapS2;
      logic [1:0] lampS1;
      logic [1:0] lampS2;
      logic togS1;
      logic togS2;
      logic togSeen;
      logic busy;
      logic [7:0] senseCnt;
      logic [4:0] phyAddr;
      logic softRst;
      logic loopback;
      logic anEnable;
      logic powerDown;
      mcms_lamp_mode_t lampAMode;
      mcms_lamp_mode_t lampBMode;
      logic lampASensedLow;
      logic lampBSensedLow;
      logic linkHold;
      logic faultHold;
      logic jabHold;
      logic pageHold;
      logic [4:0] scanAddr;
      logic lampAOut;
      logic lampBOut;
      logic lampOe;
   } mcms_core_st_t;

endpackage

// ===== mcms_dual_ram.sv
// 32 x 16 mirror of the register read view, written on the core clock
// assumes the read side clock is the management clock; read data are registered
`timescale 1ns/100ps
module mcms_dual_ram
(
   input wire logic wrClk,
   input wire logic wrEn,
   input wire logic [4:0] wrAddr,
   input wire logic [15:0] wrData,
   input wire logic rdClk,
   input wire logic [4:0] rdAddr,
   output logic [15:0] rdData
);

   logic [15:0] mem [0:31];

   // write port, one word per core cycle
   always_ff @(posedge wrClk)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
   end

   // read port; a word rewritten in the same instant may read torn, the scan makes it rare
   always_ff @(posedge rdClk)
   begin
      rdData <= mem[rdAddr];
   end

endmodule

// ===== mcms_mgmt_slave.sv
// two-wire management slave: frame decode on the management clock, registers on clk
// assumes the host drives mdio around the rising edge of mgmtClk and samples on it
// Contract
// R1: frame is start, op, phy, reg, turn, data
// R2: start 01; op 01 write, 10 read
// R3: two turnaround bits before the data field
// R4: data shifted most significant bit first
// R5: act only on own phy address
// R6: perform register reads and writes for host
// R7: straps load defaults at every reset event
// R8: hold-low bits stay low until read
// R9: hold-high bits stay high until read
// R10: writable autoclear bits clear when action completes
// R11: read-only autoclear bits unwritable, clear when consumed
// R12: sense lamp polarity at every reset event
// R13: each lamp polarity resolved on its own
// R14: host clocks link, releases line on reads
// R15: device drives zero then data, else released
// R16: bad start or opcode frames are ignored
`timescale 1ns/100ps
`include "mcms_regs.svh"
module mcms_mgmt_slave
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic mgmtClk,
   input wire logic mdioIn,
   output logic mdioOut,
   output logic mdioOe,
   input wire logic [4:0] strapPhyAddr,
   input wire logic strapAnEnable,
   input wire logic strapPowerDown,
   input wire logic linkUp,
   input wire logic remoteFault,
   input wire logic jabber,
   input wire logic pageEvent,
   input wire logic lampAOn,
   input wire logic lampBOn,
   input wire logic statusLampAIn,
   input wire logic statusLampBIn,
   output logic statusLampAOut,
   output logic statusLampBOut,
   output logic statusLampOe,
   output logic loopback,
   output logic anEnable,
   output logic powerDown
);

   mcms_pkg::mcms_link_st_t link;
   mcms_pkg::mcms_link_st_t next_link;
   mcms_pkg::mcms_core_st_t core;
   mcms_pkg::mcms_core_st_t next_core;
   logic [15:0] ramData;
   logic [15:0] shiftIn;
   logic [15:0] viewWord;
   logic hostEvent;
   logic readClear;

   // register view as the host sees it; also the word written into the mirror
   function automatic logic [15:0] regView
   (
      input logic [4:0] addr,
      input mcms_pkg::mcms_core_st_t c
   );
      logic [15:0] v;
      v = 16'h0000;
      case (addr)
         `MCMS_REG_CTRL:
         begin
            v[`MCMS_CTRL_RST] = c.softRst;
            v[`MCMS_CTRL_LOOP] = c.loopback;
            v[`MCMS_CTRL_ANEN] = c.anEnable;
            v[`MCMS_CTRL_PDN] = c.powerDown;
         end
         `MCMS_REG_STAT:
         begin
            v[`MCMS_STAT_RFLT] = c.faultHold;
            v[`MCMS_STAT_LINK] = c.linkHold;
            v[`MCMS_STAT_JAB] = c.jabHold;
         end
         `MCMS_REG_EVT:
         begin
            v[`MCMS_EVT_PAGE] = c.pageHold;
         end
         `MCMS_REG_LAMP:
         begin
            v[`MCMS_LAMP_A_LSB +: 2] = c.lampAMode;
            v[`MCMS_LAMP_B_LSB +: 2] = c.lampBMode;
            v[`MCMS_LAMP_A_SENSED] = c.lampASensedLow;
            v[`MCMS_LAMP_B_SENSED] = c.lampBSensedLow;
         end
         default:
         begin
            v = 16'h0000;
         end
      endcase
      return v;
   endfunction

   // pin level for a lamp; a pin that read high at reset is wired for active low
   function automatic logic lampLevel
   (
      input logic lampOn,
      input mcms_pkg::mcms_lamp_mode_t mode,
      input logic sensedLow
   );
      logic low;
      low = 1'b0;
      case (mode)
         mcms_pkg::MCMS_LAMP_AUTO: low = sensedLow;
         mcms_pkg::MCMS_LAMP_LOW: low = 1'b1;
         default: low = 1'b0;
      endcase
      return lampOn ^ low;
   endfunction

   // mirror of the read view; the link side reads it without waiting on a handshake
   mcms_dual_ram u_ram
   (
      .wrClk(clk),
      .wrEn(rst_b),
      .wrAddr(core.scanAddr),
      .wrData(viewWord),
      .rdClk(mgmtClk),
      .rdAddr(link.regAddr),
      .rdData(ramData)
   );

   assign viewWord = regView(core.scanAddr, core);

   // link side: frame decode and read data shifting on the host's clock
   always_comb
   begin
      next_link = link;
      shiftIn = {link.sreg[14:0], mdioIn};
      next_link.sreg = shiftIn;
      next_link.lastBit = mdioIn;
      next_link.rstS1 = rst_b;
      next_link.rstS2 = link.rstS1;
      // phy address only moves at the end of a reset sequence, no frame in flight then
      next_link.phyS1 = core.phyAddr;
      next_link.phyS2 = link.phyS1;
      case (link.state)
         mcms_pkg::MCMS_IDLE:
         begin
            // a zero after the preamble ones is the first start bit
            if (!mdioIn && link.lastBit)
            begin
               next_link.state = mcms_pkg::MCMS_ACTIVE;
               next_link.bitCnt = 5'h01;
            end
         end
         mcms_pkg::MCMS_ACTIVE:
         begin
            next_link.bitCnt = 5'(link.bitCnt + 5'h01);
            if (link.bitCnt == `MCMS_BIT_ST_END && shiftIn[1:0] != `MCMS_ST_C22)
            begin
               next_link.state = mcms_pkg::MCMS_IGNORE; // see R2, R16
            end
            if (link.bitCnt == `MCMS_BIT_OP_END)
            begin
               if (shiftIn[1:0] == `MCMS_OP_WRITE)
               begin
                  next_link.isWrite = 1'b1; // see R2
               end
               else if (shiftIn[1:0] == `MCMS_OP_READ)
               begin
                  next_link.isWrite = 1'b0;
               end
               else
               begin
                  next_link.state = mcms_pkg::MCMS_IGNORE; // see R16
               end
            end
            if (link.bitCnt == `MCMS_BIT_PHY_END && shiftIn[4:0] != link.phyS2)
            begin
               next_link.state = mcms_pkg::MCMS_IGNORE; // see R5
            end
            if (link.bitCnt == `MCMS_BIT_REG_END)
            begin
               next_link.regAddr = shiftIn[4:0]; // see R1, R5
            end
            // first turn bit stays released, the second is driven low
            if (link.bitCnt == `MCMS_BIT_TA1 && !link.isWrite)
            begin
               next_link.mdioOe = 1'b1; // see R3, R15
               next_link.mdioOut = 1'b0;
            end
            if (link.bitCnt == `MCMS_BIT_TA2 && !link.isWrite)
            begin
               next_link.txShift = ramData;
               next_link.readWord = ramData;
               next_link.mdioOut = ramData[15]; // see R4
            end
            if (link.bitCnt > `MCMS_BIT_TA2 && link.bitCnt != `MCMS_BIT_LAST && !link.isWrite)
            begin
               next_link.txShift = {link.txShift[14:0], 1'b0};
               next_link.mdioOut = link.txShift[14]; // see R4
            end
            if (link.bitCnt == `MCMS_BIT_LAST)
            begin
               next_link.state = mcms_pkg::MCMS_IDLE;
               next_link.mdioOe = 1'b0; // see R15
               next_link.mdioOut = 1'b0;
               next_link.postWr = link.isWrite;
               next_link.postAddr = link.regAddr;
               next_link.postData = link.isWrite ? shiftIn : link.readWord; // see R4, R6
               next_link.postToggle = ~link.postToggle;
            end
         end
         mcms_pkg::MCMS_IGNORE:
         begin
            // sit out the rest of the frame so its data cannot look like a start
            next_link.bitCnt = 5'(link.bitCnt + 5'h01);
            if (link.bitCnt == `MCMS_BIT_LAST)
            begin
               next_link.state = mcms_pkg::MCMS_IDLE;
            end
         end
         default:
         begin
            next_link.state = mcms_pkg::MCMS_IDLE;
         end
      endcase
      if (!link.rstS2)
      begin
         next_link.state = mcms_pkg::MCMS_IDLE;
         next_link.bitCnt = 5'h00;
         next_link.lastBit = 1'b0;
         next_link.isWrite = 1'b0;
         next_link.regAddr = 5'h00;
         next_link.mdioOut = 1'b0;
         next_link.mdioOe = 1'b0;
         next_link.postToggle = 1'b0;
      end
   end

   // the reset synchroniser flops carry no reset of their own
   always_ff @(posedge mgmtClk)
   begin
      link <= next_link;
   end

   // a finished frame shows up as a toggle change; its word has been stable since
   assign hostEvent = core.togS2 != core.togSeen;
   assign readClear = hostEvent && !link.postWr;

   // core side: straps, reset sequence, register semantics, lamps
   always_comb
   begin
      next_core = core;
      next_core.strapS1 = {strapPowerDown, strapAnEnable, strapPhyAddr};
      next_core.strapS2 = core.strapS1;
      next_core.lampS1 = {statusLampBIn, statusLampAIn};
      next_core.lampS2 = core.lampS1;
      next_core.togS1 = link.postToggle;
      next_core.togS2 = core.togS1;
      next_core.togSeen = core.togS2;
      next_core.scanAddr = 5'(core.scanAddr + 5'h01);
      // hold bits: the read clear is applied first so a new event in the same cycle wins
      next_core.faultHold = (readClear && link.postAddr == `MCMS_REG_STAT
         && link.postData[`MCMS_STAT_RFLT]) ? 1'b0 : core.faultHold; // see R9
      next_core.jabHold = (readClear && link.postAddr == `MCMS_REG_STAT
         && link.postData[`MCMS_STAT_JAB]) ? 1'b0 : core.jabHold; // see R9
      next_core.linkHold = (readClear && link.postAddr == `MCMS_REG_STAT
         && !link.postData[`MCMS_STAT_LINK]) ? 1'b1 : core.linkHold; // see R8
      next_core.pageHold = (readClear && link.postAddr == `MCMS_REG_EVT
         && link.postData[`MCMS_EVT_PAGE]) ? 1'b0 : core.pageHold; // see R11
      next_core.faultHold = next_core.faultHold | remoteFault;
      next_core.jabHold = next_core.jabHold | jabber;
      next_core.linkHold = next_core.linkHold & linkUp;
      next_core.pageHold = next_core.pageHold | pageEvent;
      // host writes; status and event words have no writable bits
      if (hostEvent && link.postWr)
      begin
         case (link.postAddr)
            `MCMS_REG_CTRL:
            begin
               next_core.loopback = link.postData[`MCMS_CTRL_LOOP]; // see R6
               next_core.anEnable = link.postData[`MCMS_CTRL_ANEN];
               next_core.powerDown = link.postData[`MCMS_CTRL_PDN];
               if (link.postData[`MCMS_CTRL_RST])
               begin
                  next_core.softRst = 1'b1; // see R10
                  next_core.busy = 1'b1;
                  next_core.senseCnt = 8'h00;
                  next_core.loopback = `MCMS_RST_LOOP;
                  next_core.lampAMode = mcms_pkg::mcms_lamp_mode_t'(`MCMS_RST_LAMP_MODE);
                  next_core.lampBMode = mcms_pkg::mcms_lamp_mode_t'(`MCMS_RST_LAMP_MODE);
               end
            end
            `MCMS_REG_LAMP:
            begin
               next_core.lampAMode =
                  mcms_pkg::mcms_lamp_mode_t'(link.postData[`MCMS_LAMP_A_LSB +: 2]);
               next_core.lampBMode =
                  mcms_pkg::mcms_lamp_mode_t'(link.postData[`MCMS_LAMP_B_LSB +: 2]);
            end
            default:
            begin
               next_core.softRst = core.softRst; // see R11
            end
         endcase
      end
      // reset sequence: lamps released, pins settle on their pulls, then sampled
      if (core.busy)
      begin
         next_core.senseCnt = 8'(core.senseCnt + 8'h01);
         next_core.linkHold = linkUp;
         if (core.senseCnt == 8'(`MCMS_SENSE_CYCLES - 1))
         begin
            next_core.busy = 1'b0;
            next_core.softRst = 1'b0; // see R10
            next_core.phyAddr = core.strapS2[4:0]; // see R7
            next_core.anEnable = core.strapS2[5]; // see R7
            next_core.powerDown = core.strapS2[6]; // see R7
            next_core.lampASensedLow = core.lampS2[0]; // see R12, R13
            next_core.lampBSensedLow = core.lampS2[1]; // see R12, R13
         end
      end
      next_core.lampOe = !next_core.busy; // see R12
      next_core.lampAOut = lampLevel(lampAOn, core.lampAMode, core.lampASensedLow); // see R13
      next_core.lampBOut = lampLevel(lampBOn, core.lampBMode, core.lampBSensedLow); // see R13
      if (!rst_b)
      begin
         next_core = '0;
         next_core.busy = 1'b1; // see R7, R12
         next_core.togSeen = 1'b0;
         next_core.lampAMode = mcms_pkg::mcms_lamp_mode_t'(`MCMS_RST_LAMP_MODE);
         next_core.lampBMode = mcms_pkg::mcms_lamp_mode_t'(`MCMS_RST_LAMP_MODE);
      end
   end

   // synchronous reset is folded into the next value above
   always_ff @(posedge clk)
   begin
      core <= next_core;
   end

   // every output straight from a flop
   assign mdioOut = link.mdioOut;
   assign mdioOe = link.mdioOe;
   assign statusLampAOut = core.lampAOut;
   assign statusLampBOut = core.lampBOut;
   assign statusLampOe = core.lampOe;
   assign loopback = core.loopback;
   assign anEnable = core.anEnable;
   assign powerDown = core.powerDown;

endmodule

// ===== mcms_host_model.sv
// host side of the two-wire management link: makes the link clock and frames
// assumes a pull-up on the data line; the clock stands still between frames
`timescale 1ns/100ps
module mcms_host_model
(
   output logic mgmtClk,
   output logic mdioIn,
   input wire logic mdioOut,
   input wire logic mdioOe
);
   logic hostOe;
   logic hostBit;

   // resolved line: the pull-up wins when nobody drives
   always_comb
   begin
      if (mdioOe)
         mdioIn = mdioOut;
      else if (hostOe)
         mdioIn = hostBit;
      else
         mdioIn = 1'b1;
   end

   // idle line and clock at time zero
   initial
   begin
      mgmtClk = 1'b0;
      hostOe = 1'b0;
      hostBit = 1'b1;
   end

   // one 6 ns bit: value set after the fall, line sampled just before the rise
   task automatic bit_cycle(input logic drive, input logic val, output logic seen);
      mgmtClk = 1'b0;
      hostOe = drive;
      hostBit = val;
      #3;
      seen = mdioIn;
      mgmtClk = 1'b1;
      #3;
   endtask

   // released clocks, used while reset is held and just after it is released
   task automatic idle(input int n);
      logic s;
      repeat (n) bit_cycle(1'b0, 1'b1, s);
      mgmtClk = 1'b0;
   endtask

   // whole frame, msb first, with two preamble ones and two trailing released bits
   task automatic frame(input logic [1:0] st, input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd, output logic ta2);
      logic [31:0] f;
      logic s;
      logic rdOp;
      f = {st, op, phy, ra, 2'b10, wd};
      rdOp = (op == 2'b10);
      rd = 16'h0000;
      ta2 = 1'b1;
      bit_cycle(1'b0, 1'b1, s);
      bit_cycle(1'b1, 1'b1, s);
      for (int i = 0; i < 32; i++)
      begin
         bit_cycle(!(rdOp && i >= 14), f[31 - i], s);
         if (i == 15)
            ta2 = s;
         if (i >= 16)
            rd[31 - i] = s;
      end
      bit_cycle(1'b0, 1'b1, s);
      bit_cycle(1'b0, 1'b1, s);
      mgmtClk = 1'b0;
   endtask
endmodule

// ===== mcms_mgmt_slave_properties.sv
// concurrent checks on the management slave ports, both clock domains
// assumes straps are held steady and the host clocks only within frames
`timescale 1ns/100ps
module mcms_mgmt_slave_properties
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic mgmtClk,
   input wire logic mdioIn,
   input wire logic mdioOut,
   input wire logic mdioOe,
   input wire logic strapAnEnable,
   input wire logic strapPowerDown,
   input wire logic [4:0] strapPhyAddr,
   input wire logic statusLampOe,
   input wire logic statusLampAOut,
   input wire logic statusLampBOut,
   input wire logic loopback,
   input wire logic anEnable,
   input wire logic powerDown
);
   // read header seen 15 bits before the line is taken
   sequence rd_header;
      !$past(mdioIn, 15) && $past(mdioIn, 14) && $past(mdioIn, 13) && !$past(mdioIn, 12);
   endsequence
   // seventeen driven bits, then released
   sequence drive_span;
      mdioOe[*8] ##1 mdioOe[*8] ##1 mdioOe ##1 !mdioOe;
   endsequence
   // lamps undriven for the 20 cycle sensing window
   sequence sense_dark;
      (!statusLampOe)[*8] ##1 (!statusLampOe)[*8] ##1 (!statusLampOe)[*4] ##[0:8] statusLampOe;
   endsequence

   a_read_header: assert property (
      @(posedge mgmtClk) disable iff (!rst_b) $rose(mdioOe) |-> rd_header)
      else $error("line driven without a read header");
   a_read_addr: assert property (
      @(posedge mgmtClk) disable iff (!rst_b) $rose(mdioOe) |-> {$past(mdioIn, 11),
      $past(mdioIn, 10), $past(mdioIn, 9), $past(mdioIn, 8), $past(mdioIn, 7)} == strapPhyAddr)
      else $error("line driven for another phy address");
   a_turn_zero: assert property (
      @(posedge mgmtClk) disable iff (!rst_b) $rose(mdioOe) |-> !mdioOut)
      else $error("second turnaround bit not zero");
   a_drive_span: assert property (
      @(posedge mgmtClk) disable iff (!rst_b) $rose(mdioOe) |-> drive_span)
      else $error("read drive span wrong");
   a_reset_clear: assert property (
      @(posedge clk) disable iff (!rst_b)
      $rose(rst_b) |-> !loopback && !statusLampAOut && !statusLampBOut)
      else $error("outputs not cleared by reset");
   a_sense_window: assert property (
      @(posedge clk) disable iff (!rst_b) $rose(rst_b) |-> sense_dark)
      else $error("sensing window length wrong");
   a_strap_load: assert property (
      @(posedge clk) disable iff (!rst_b) $rose(statusLampOe) |->
      anEnable == strapAnEnable && powerDown == strapPowerDown && !loopback)
      else $error("strap defaults not loaded");
   a_soft_clear: assert property (
      @(posedge clk) disable iff (!rst_b) $fell(statusLampOe) |-> ##2 !loopback)
      else $error("loopback survives reset sequence");
endmodule

bind mcms_mgmt_slave mcms_mgmt_slave_properties props_i (.clk(clk), .rst_b(rst_b),
   .mgmtClk(mgmtClk), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe),
   .strapAnEnable(strapAnEnable), .strapPowerDown(strapPowerDown),
   .strapPhyAddr(strapPhyAddr), .statusLampOe(statusLampOe),
   .statusLampAOut(statusLampAOut), .statusLampBOut(statusLampBOut),
   .loopback(loopback), .anEnable(anEnable), .powerDown(powerDown));

// ===== tb.sv
// self-checking bench for the management slave with a host model on the link
// assumes the slave answers at strap address 5'h0a with autoneg strapped on
`timescale 1ns/100ps
`define CHK(a, e) check16(16'(a), 16'(e))
module tb;
   localparam logic [4:0] PHY = 5'h0a;
   logic clk;
   logic rst_b;
   logic mgmtClk, mdioIn, mdioOut, mdioOe;
   logic linkUp, remoteFault, jabber, pageEvent, lampAOn, lampBOn;
   logic statusLampAOut, statusLampBOut, statusLampOe, loopback, anEnable, powerDown;
   logic [15:0] d;
   logic ta;
   int mismatches = 0;
   int nChecks = 0;

   mcms_host_model host (.mgmtClk(mgmtClk), .mdioIn(mdioIn), .mdioOut(mdioOut),
      .mdioOe(mdioOe));
   mcms_mgmt_slave mcms_mgmt_slave_i (.clk(clk), .rst_b(rst_b), .mgmtClk(mgmtClk),
      .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe), .strapPhyAddr(PHY),
      .strapAnEnable(1'b1), .strapPowerDown(1'b0), .linkUp(linkUp),
      .remoteFault(remoteFault), .jabber(jabber), .pageEvent(pageEvent),
      .lampAOn(lampAOn), .lampBOn(lampBOn),
      .statusLampAIn(statusLampOe ? statusLampAOut : 1'b1),
      .statusLampBIn(statusLampOe ? statusLampBOut : 1'b0),
      .statusLampAOut(statusLampAOut), .statusLampBOut(statusLampBOut),
      .statusLampOe(statusLampOe), .loopback(loopback), .anEnable(anEnable),
      .powerDown(powerDown));

   // 200 MHz core clock
   always #2.5 clk = ~clk;

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check16(input logic [15:0] a, input logic [15:0] e);
      nChecks++;
      if (a !== e)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", nChecks, mismatches);
      if (mismatches == 0 && nChecks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // bus cycles; the leading wait lets the read mirror catch up
   task automatic wr(input logic [4:0] ra, input logic [15:0] v);
      host.frame(2'b01, 2'b01, PHY, ra, v, d, ta);
      step(8);
   endtask
   task automatic rd(input logic [4:0] ra);
      step(34);
      host.frame(2'b01, 2'b10, PHY, ra, 16'h0000, d, ta);
      `CHK(ta, 1'b0);
      // realign to the core clock so later stimulus lands just after an edge
      step(1);
   endtask

   task automatic s_defaults_and_rw();
      `CHK({loopback, anEnable, powerDown}, 3'h2);
      rd(5'h00);
      `CHK(d, 16'h1000);
      wr(5'h00, 16'h4800);
      `CHK({loopback, anEnable, powerDown}, 3'h5);
      rd(5'h00);
      `CHK(d, 16'h4800);
   endtask
   // foreign address and malformed codes must leave everything alone
   task automatic s_ignored();
      logic [3:0] codes [4] = '{4'h1, 4'h2, 4'h4, 4'h7};
      host.frame(2'b01, 2'b01, PHY ^ 5'h01, 5'h00, 16'h0000, d, ta);
      host.frame(2'b01, 2'b10, PHY ^ 5'h01, 5'h00, 16'h0000, d, ta);
      `CHK(d, 16'hffff);
      `CHK(ta, 1'b1);
      foreach (codes[k])
         host.frame(codes[k][3:2], codes[k][1:0], PHY, 5'h00, 16'h0000, d, ta);
      step(8);
      `CHK({loopback, powerDown}, 2'h3);
   endtask
   // soft reset reloads straps, resenses lamps and clears itself
   task automatic s_soft_reset();
      wr(5'h00, 16'h8000);
      // anEnable and powerDown follow the written word until the straps reload at the end; loopback takes its reset value
      `CHK({statusLampOe, loopback, anEnable, powerDown}, 4'h0);
      step(40);
      `CHK(statusLampOe, 1'b1);
      rd(5'h00);
      `CHK(d, 16'h1000);
   endtask
   task automatic s_lamps();
      for (int v = 0; v < 2; v++)
      begin
         lampAOn = v[0];
         lampBOn = v[0];
         step(3);
         `CHK({statusLampAOut, statusLampBOut}, {!v[0], v[0]});
      end
      rd(5'h03);
      `CHK(d, 16'h0100);
      lampBOn = 1'b0;
      for (int m = 1; m < 4; m++)
      begin
         wr(5'h03, 16'(m * 5));
         `CHK({statusLampAOut, statusLampBOut}, {m != 2, m == 2});
      end
   endtask
   // latched status and consumed event bits
   task automatic s_holds();
      wr(5'h02, 16'h0001);
      rd(5'h02);
      `CHK(d, 16'h0000);
      {linkUp, remoteFault, jabber, pageEvent} = 4'h7;
      step(2);
      {linkUp, remoteFault, jabber, pageEvent} = 4'h8;
      rd(5'h01);
      `CHK(d, 16'h0012);
      rd(5'h01);
      `CHK(d, 16'h0004);
      rd(5'h02);
      `CHK(d, 16'h0001);
      rd(5'h02);
      `CHK(d, 16'h0000);
   endtask

   // main sequence: reset with link clocks running, then the scenarios
   initial
   begin
      clk = 1'b0;
      rst_b = 1'b0;
      {linkUp, remoteFault, jabber, pageEvent, lampAOn, lampBOn} = 6'h20;
      fork
         host.idle(8);
         step(20);
      join
      rst_b = 1'b1;
      // the link side reset synchroniser only moves on link clocks
      host.idle(4);
      step(80);
      s_defaults_and_rw();
      s_ignored();
      s_soft_reset();
      s_lamps();
      s_holds();
      summarize();
   end

   // watchdog well beyond the expected 7 us of traffic
   initial
   begin
      #100000;
      mismatches++;
      summarize();
   end
endmodule
